// ===== rtl/tsc_consts.vh
// constants for the two-way set-associative cache
// Functional notes
// - two sets, virtually indexed, holding both instructions and operands
// - each set has 16K entries of two 32-bit words, 256KB in total
// - an access completes within one beat, so one may start every beat
// - each entry keeps upper address bits, validity and age history
// - low bits index the RAMs; hit is tag equal and valid, beside the read
// - both sets compare at once and either may signal the hit
// - on a read miss, send line address and read request; hold pipe until data
// - each miss returns 64 bits and all are written into the entry
// - the set to refill is chosen by least recent use
// - fill data is captured in registers and shown on the bus one beat
// - operand reads access at stage 7 and latch data at beat end
// - data registers have even and odd halves; reads are 16 or 32 bits
// - a 32-bit read at an odd address takes one extra beat
// - write data from the execution bus is written 1.5 beats after stage 7
// - writes may be 16 or 32 bits wide
// - an odd 32-bit write takes four extra beats: reload then three to write
// - each set decides its hit, the bus drives address then data, parity checked
// - an instruction fetch miss holds the odd stage clocks within the beat
// - an operand miss holds the even stage clocks within the beat
// - a memory trap cancels a pending miss sequence
// - execution bus latch control rises at stage 7, falls before beat end
// - opcode latch control rises at stage 2, falls before beat end
`ifndef TSC_CONSTS_VH
`define TSC_CONSTS_VH
`define TSC_INDEX_W 14
`define TSC_ADDR_W 32
`define TSC_PADDR_W 12
`define TSC_CLK_NS 5
`define TSC_BEAT_NS 10
`define TSC_BEAT_CYC ((`TSC_BEAT_NS + `TSC_CLK_NS - 1) / `TSC_CLK_NS)
`define TSC_WR_DLY_NS 15
`define TSC_WR_DLY_CYC ((`TSC_WR_DLY_NS + `TSC_CLK_NS - 1) / `TSC_CLK_NS)
`define TSC_UWR_BEATS 4
`define TSC_REG_CTRL 12'h000
`define TSC_REG_STATUS 12'h004
`define TSC_REG_HITS 12'h008
`define TSC_REG_MISSES 12'h00C
`define TSC_CTRL_PAR_EN 0
`define TSC_STAT_PAR_ERR 0
`define TSC_STAT_BUSY 1
`define TSC_STAT_MISS 2
`define TSC_CTRL_RESET 1'h1
`endif

// ===== rtl/tsc_set.v
// one cache set: data, tag, validity and parity storage with hit compare
`timescale 1ns/1ps
module tsc_set #(
  parameter INDEX_W = 14,
  parameter TAG_W   = 16
) (
  input  wire               pclk,
  input  wire               presetn,
  input  wire [INDEX_W-1:0] index,
  input  wire [TAG_W-1:0]   tag_in,
  output wire               hit,
  output wire               valid,
  output wire [63:0]        line,
  output wire               par_err,
  input  wire               wr_en,
  input  wire               wr_fill,
  input  wire [3:0]         wr_mask,
  input  wire [63:0]        wr_line
);
  localparam DEPTH = 1 << INDEX_W;
  reg [63:0]      data [0:DEPTH-1];
  reg [TAG_W-1:0] tags [0:DEPTH-1];
  reg [3:0]       par  [0:DEPTH-1];
  reg             vld  [0:DEPTH-1];
  wire [3:0]      wpar;
  integer         i;
  integer         p;

  function [3:0] par4;
    input [63:0] l;
    par4 = {^l[15:0], ^l[31:16], ^l[47:32], ^l[63:48]};
  endfunction

  assign wpar    = par4(wr_line);
  assign line    = data[index];
  assign valid   = vld[index];
  assign hit     = vld[index] & (tags[index] == tag_in);
  assign par_err = |(par[index] ^ par4(data[index]));

  always @(posedge pclk) begin
    if (wr_en) begin
      for (p = 0; p < 4; p = p + 1) begin
        if (wr_mask[p]) begin
          data[index][63-16*p -: 16] <= wr_line[63-16*p -: 16];
          par[index][p] <= wpar[p];
        end
      end
      if (wr_fill)
        tags[index] <= tag_in;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < DEPTH; i = i + 1)
        vld[i] <= 1'h0;
    end else if (wr_en && wr_fill) begin
      vld[index] <= 1'h1;
    end
  end
endmodule

// ===== rtl/tsc_cache.v
// two-way set-associative instruction and operand cache with apb status
`timescale 1ns/1ps
`include "tsc_consts.vh"
module tsc_cache #(
  parameter INDEX_W = `TSC_INDEX_W,
  parameter ADDR_W  = `TSC_ADDR_W
) (
  input  wire                    pclk,
  input  wire                    presetn,
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [`TSC_PADDR_W-1:0] paddr,
  input  wire [31:0]             pwdata,
  output reg  [31:0]             prdata,
  output reg                     pready,
  output reg                     pslverr,
  input  wire                    stage2_clock_edge,
  input  wire                    stage7_clock_edge,
  input  wire [ADDR_W-1:0]       instruction_stream_counter,
  input  wire [ADDR_W-1:0]       operand_effective_address,
  input  wire                    op_write,
  input  wire                    op_wide,
  input  wire [31:0]             execution_data_bus,
  input  wire                    mem_trap,
  input  wire                    mem_ack,
  input  wire [63:0]             mem_data,
  output reg                     mem_req,
  output reg  [ADDR_W-1:0]       memory_address_reg,
  output reg  [63:0]             shared_memory_bus,
  output reg                     fill_valid,
  output reg  [15:0]             cache_data_even,
  output reg  [15:0]             cache_data_odd,
  output reg                     rd_done,
  output reg                     wr_done,
  output reg                     hold_odd_stages,
  output reg                     hold_even_stages,
  output reg                     exec_bus_latch_ctl,
  output reg                     opcode_latch_ctl,
  output reg                     parity_error
);
  localparam TAG_W = ADDR_W - INDEX_W - 2;
  localparam DEPTH = 1 << INDEX_W;
  localparam S_IDLE  = 3'h0;
  localparam S_LOOK  = 3'h1;
  localparam S_WRITE = 3'h2;
  localparam S_WAIT  = 3'h3;
  localparam S_MISS  = 3'h4;
  localparam S_FILL  = 3'h5;
  localparam [31:0] BEAT_LAST = `TSC_BEAT_CYC - 1;
  localparam [31:0] BEAT_WAIT = `TSC_BEAT_CYC - 2;
  localparam [31:0] WR_WAIT   = `TSC_WR_DLY_CYC - 2;
  localparam [31:0] UWR_WAIT  = `TSC_UWR_BEATS * `TSC_BEAT_CYC - 2;

  reg  [2:0]         state;
  reg  [3:0]         cnt;
  reg  [ADDR_W-1:0]  a_addr;
  reg                a_instr;
  reg                a_write;
  reg                a_wide;
  reg                second;
  reg  [31:0]        wdata;
  reg                mru [0:DEPTH-1];
  reg                ctrl_par_en;
  reg  [31:0]        hit_count;
  reg  [31:0]        miss_count;
  reg                wr_en;
  reg                wr_fill;
  reg                wr_set;
  reg  [3:0]         wr_mask;
  reg  [63:0]        wr_line;
  reg  [31:0]        rd_mux;
  reg                rd_map;
  wire [INDEX_W-1:0] idx;
  wire [TAG_W-1:0]   tag;
  wire [1:0]         hw;
  wire [1:0]         hit;
  wire [1:0]         vld;
  wire [1:0]         perr;
  wire [127:0]       lines;
  wire               hit_any;
  wire [63:0]        sel_line;
  wire               victim;
  wire               hit_ev;
  wire               miss_ev;
  wire               par_set;
  wire               apb_wr;
  wire               par_clr;
  integer            i;
  genvar             g;

  function [15:0] lane;
    input [63:0] l;
    input [1:0]  p;
    case (p)
      2'h0:    lane = l[63:48];
      2'h1:    lane = l[47:32];
      2'h2:    lane = l[31:16];
      default: lane = l[15:0];
    endcase
  endfunction

  // address bits above the halfword select pick the entry directly, the bits above the index form the tag
  assign idx = a_addr[INDEX_W+1:2];
  assign tag = a_addr[ADDR_W-1:INDEX_W+2];
  assign hw  = a_addr[1:0];

  generate
    for (g = 0; g < 2; g = g + 1) begin : set_gen
      tsc_set #(
        .INDEX_W (INDEX_W),
        .TAG_W   (TAG_W)
      ) u_set (
        .pclk    (pclk),
        .presetn (presetn),
        .index   (idx),
        .tag_in  (tag),
        .hit     (hit[g]),
        .valid   (vld[g]),
        .line    (lines[64*g+63:64*g]),
        .par_err (perr[g]),
        .wr_en   (wr_en && (wr_set == g)),
        .wr_fill (wr_fill),
        .wr_mask (wr_mask),
        .wr_line (wr_line)
      );
    end
  endgenerate

  // both sets compare in the same cycle; either one may answer
  assign hit_any  = |hit;
  assign sel_line = hit[1] ? lines[127:64] : lines[63:0];
  // an empty way is used before evicting the older one
  assign victim   = !vld[0] ? 1'h0 : (!vld[1] ? 1'h1 : !mru[idx]);
  assign hit_ev   = (state == S_LOOK) && hit_any;
  assign miss_ev  = (state == S_LOOK) && !hit_any && !a_write && !mem_trap;
  assign par_set  = hit_ev && ctrl_par_en && (hit[1] ? perr[1] : perr[0]);

  // write port steering for fills and write hits
  always @* begin
    wr_en   = 1'h0;
    wr_fill = 1'h0;
    wr_set  = hit[1];
    wr_mask = 4'h1 << hw;
    wr_line = {4{execution_data_bus[15:0]}};
    if (state == S_MISS && mem_ack && !mem_trap) begin
      wr_en   = 1'h1;
      wr_fill = 1'h1;
      wr_set  = victim;
      wr_mask = 4'hF;
      wr_line = mem_data;
    end else if (state == S_LOOK && hit_any && a_write && second) begin
      wr_en   = 1'h1;
      wr_line = {4{wdata[15:0]}};
    end else if (state == S_WRITE && cnt == 4'h0 && hit_any) begin
      wr_en = 1'h1;
      if (a_wide && !hw[0]) begin
        wr_line = {2{execution_data_bus}};
        wr_mask = hw[1] ? 4'hC : 4'h3;
      end else if (a_wide) begin
        wr_line = {4{execution_data_bus[31:16]}};
      end
    end
  end

  // latch controls are one clock wide, i.e. half a beat
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exec_bus_latch_ctl <= 1'h0;
      opcode_latch_ctl   <= 1'h0;
    end else begin
      exec_bus_latch_ctl <= stage7_clock_edge;
      opcode_latch_ctl   <= stage2_clock_edge;
    end
  end

  // history bits; reset so a fresh victim choice is never unknown
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < DEPTH; i = i + 1)
        mru[i] <= 1'h0;
    end else if (hit_ev) begin
      mru[idx] <= hit[1];
    end else if (wr_en && wr_fill) begin
      mru[idx] <= victim;
    end
  end

  // access sequencer, one lookup per beat
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state              <= S_IDLE;
      cnt                <= 4'h0;
      a_addr             <= {ADDR_W{1'h0}};
      a_instr            <= 1'h0;
      a_write            <= 1'h0;
      a_wide             <= 1'h0;
      second             <= 1'h0;
      wdata              <= 32'h0;
      mem_req            <= 1'h0;
      memory_address_reg <= {ADDR_W{1'h0}};
      shared_memory_bus  <= 64'h0;
      fill_valid         <= 1'h0;
      cache_data_even    <= 16'h0;
      cache_data_odd     <= 16'h0;
      rd_done            <= 1'h0;
      wr_done            <= 1'h0;
      hold_odd_stages    <= 1'h0;
      hold_even_stages   <= 1'h0;
    end else begin
      rd_done <= 1'h0;
      wr_done <= 1'h0;
      case (state)
        S_IDLE: begin
          second <= 1'h0;
          // operand access wins if both stage edges come together
          if (stage7_clock_edge) begin
            a_addr  <= operand_effective_address;
            a_instr <= 1'h0;
            a_write <= op_write;
            a_wide  <= op_wide;
            state   <= S_LOOK;
          end else if (stage2_clock_edge) begin
            a_addr  <= instruction_stream_counter;
            a_instr <= 1'h1;
            a_write <= 1'h0;
            a_wide  <= 1'h1;
            state   <= S_LOOK;
          end
        end
        S_LOOK: begin
          hold_odd_stages  <= 1'h0;
          hold_even_stages <= 1'h0;
          if (hit_any) begin
            if (a_write && second) begin
              wr_done <= 1'h1;
              state   <= S_IDLE;
            end else if (a_write) begin
              cnt   <= WR_WAIT[3:0];
              state <= S_WRITE;
            end else begin
              if (!a_wide || second || hw[0]) begin
                if (hw[0])
                  cache_data_odd <= lane(sel_line, hw);
                else
                  cache_data_even <= lane(sel_line, hw);
              end else begin
                cache_data_even <= lane(sel_line, hw);
                cache_data_odd  <= lane(sel_line, hw + 2'h1);
              end
              if (a_wide && hw[0] && !second) begin
                a_addr <= a_addr + {{(ADDR_W-1){1'h0}}, 1'h1};
                second <= 1'h1;
                cnt    <= BEAT_WAIT[3:0];
                state  <= S_WAIT;
              end else begin
                rd_done <= 1'h1;
                state   <= S_IDLE;
              end
            end
          end else if (mem_trap) begin
            state <= S_IDLE;
          end else if (a_write) begin
            // write miss does not allocate; the line stays out
            wr_done <= 1'h1;
            state   <= S_IDLE;
          end else begin
            mem_req            <= 1'h1;
            memory_address_reg <= {a_addr[ADDR_W-1:2], 2'h0};
            hold_odd_stages    <= a_instr;
            hold_even_stages   <= !a_instr;
            state              <= S_MISS;
          end
        end
        S_WRITE: begin
          if (cnt == 4'h0) begin
            wdata <= execution_data_bus;
            if (a_wide && hw[0]) begin
              a_addr <= a_addr + {{(ADDR_W-1){1'h0}}, 1'h1};
              second <= 1'h1;
              cnt    <= UWR_WAIT[3:0];
              state  <= S_WAIT;
            end else begin
              wr_done <= 1'h1;
              state   <= S_IDLE;
            end
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        S_WAIT: begin
          if (cnt == 4'h0)
            state <= S_LOOK;
          else
            cnt <= cnt - 4'h1;
        end
        S_MISS: begin
          if (mem_trap) begin
            mem_req          <= 1'h0;
            hold_odd_stages  <= 1'h0;
            hold_even_stages <= 1'h0;
            state            <= S_IDLE;
          end else if (mem_ack) begin
            mem_req           <= 1'h0;
            shared_memory_bus <= mem_data;
            fill_valid        <= 1'h1;
            cnt               <= BEAT_LAST[3:0];
            state             <= S_FILL;
          end
        end
        S_FILL: begin
          // the replayed lookup then hits and releases the stall
          if (cnt == 4'h0) begin
            fill_valid <= 1'h0;
            state      <= S_LOOK;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // apb slave, one wait-free access phase per transfer
  assign apb_wr  = psel && penable && pready && pwrite;
  assign par_clr = apb_wr && (paddr == `TSC_REG_STATUS) && pwdata[`TSC_STAT_PAR_ERR];

  always @* begin
    rd_map = 1'h1;
    rd_mux = 32'h0;
    case (paddr)
      `TSC_REG_CTRL:   rd_mux[`TSC_CTRL_PAR_EN] = ctrl_par_en;
      `TSC_REG_STATUS: begin
        rd_mux[`TSC_STAT_PAR_ERR] = parity_error;
        rd_mux[`TSC_STAT_BUSY]    = (state != S_IDLE);
        rd_mux[`TSC_STAT_MISS]    = mem_req;
      end
      `TSC_REG_HITS:   rd_mux = hit_count;
      `TSC_REG_MISSES: rd_mux = miss_count;
      default:         rd_map = 1'h0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready       <= 1'h0;
      prdata       <= 32'h0;
      pslverr      <= 1'h0;
      ctrl_par_en  <= `TSC_CTRL_RESET;
      parity_error <= 1'h0;
      hit_count    <= 32'h0;
      miss_count   <= 32'h0;
    end else begin
      pready  <= psel && !penable && !pready;
      pslverr <= psel && !penable && !pready && !rd_map;
      if (psel && !penable)
        prdata <= rd_mux;
      if (apb_wr && paddr == `TSC_REG_CTRL)
        ctrl_par_en <= pwdata[`TSC_CTRL_PAR_EN];
      // a new parity error in the clearing cycle stays set
      parity_error <= (parity_error && !par_clr) || par_set;
      if (hit_ev)
        hit_count <= hit_count + 32'h1;
      if (miss_ev)
        miss_count <= miss_count + 32'h1;
    end
  end
endmodule

// ===== tb/tsc_cache_asserts.sv
// port checker for the two-way cache
`timescale 1ns/1ps
module tsc_cache_asserts (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pready,
  input logic        stage2_clock_edge,
  input logic        stage7_clock_edge,
  input logic        mem_trap,
  input logic        mem_ack,
  input logic [63:0] mem_data,
  input logic        mem_req,
  input logic [31:0] memory_address_reg,
  input logic [63:0] shared_memory_bus,
  input logic        fill_valid,
  input logic        rd_done,
  input logic        wr_done,
  input logic        hold_odd_stages,
  input logic        hold_even_stages,
  input logic        exec_bus_latch_ctl,
  input logic        opcode_latch_ctl
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_exec_latch_pulse: assert property (stage7_clock_edge |=> exec_bus_latch_ctl ##1 !exec_bus_latch_ctl)
    else $error("execution bus latch control pulse wrong");
  a_opcode_latch_pulse: assert property (stage2_clock_edge |=> opcode_latch_ctl ##1 !opcode_latch_ctl)
    else $error("opcode latch control pulse wrong");
  a_fill_one_beat: assert property ($rose(fill_valid) |=> fill_valid ##1 !fill_valid)
    else $error("fill data not shown for exactly one beat");
  a_fill_data_taken: assert property (mem_req && mem_ack |=>
    fill_valid && !mem_req && shared_memory_bus == $past(mem_data))
    else $error("returned line not captured and shown");
  a_req_held: assert property (mem_req && !mem_ack && !mem_trap |=>
    mem_req && $stable(memory_address_reg))
    else $error("miss request dropped or moved before answer");
  a_trap_cancel: assert property (mem_req && mem_trap && !mem_ack |=> !mem_req && !fill_valid)
    else $error("trap did not cancel pending miss");
  a_miss_stalls: assert property (mem_req |-> hold_odd_stages || hold_even_stages)
    else $error("miss pending without a stage hold");
  a_line_address: assert property ($rose(mem_req) |-> memory_address_reg[1:0] == 2'b00)
    else $error("miss address not a line address");
  a_done_pulse: assert property (rd_done |=> !rd_done)
    else $error("read done longer than one cycle");
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no answer in the access phase");

  c_fill: cover property ($rose(fill_valid));
  c_write: cover property (wr_done);
  c_trap: cover property (mem_req && mem_trap);
endmodule

bind tsc_cache tsc_cache_asserts i_tsc_cache_asserts (.*);

// ===== tb/tsc_mem_model.sv
// memory controller model answering miss reads
`timescale 1ns/1ps
module tsc_mem_model (
  input  logic        pclk,
  input  logic        presetn,
  input  logic [3:0]  lat,
  input  logic        mem_req,
  input  logic [31:0] memory_address_reg,
  output logic        mem_ack,
  output logic [63:0] mem_data
);
  logic [3:0] cnt;

  function automatic logic [15:0] hw(input logic [31:0] a);
    return {a[7:0], a[23:16]} ^ 16'h3C00;
  endfunction

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack  <= 1'b0;
      mem_data <= 64'h0;
      cnt      <= 4'h0;
    end else if (mem_req && !mem_ack && cnt == lat) begin
      mem_ack  <= 1'b1;
      mem_data <= {hw(memory_address_reg), hw(memory_address_reg + 32'h1),
                   hw(memory_address_reg + 32'h2), hw(memory_address_reg + 32'h3)};
      cnt      <= 4'h0;
    end else begin
      mem_ack  <= 1'b0;
      // a stale line must not look valid after the answer cycle
      mem_data <= ~mem_data;
      cnt      <= (mem_req && !mem_ack) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule

// ===== tb/tsc_cache_tb_top.sv
// self-checking bench for the two-way cache
`timescale 1ns/1ps
module tsc_cache_tb_top;
  localparam logic [31:0] A = 32'h0001_0000;
  localparam logic [31:0] B = 32'h0002_0000;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, instruction_stream_counter, operand_effective_address;
  logic [31:0] execution_data_bus, memory_address_reg;
  logic        stage2_clock_edge, stage7_clock_edge, op_write, op_wide, mem_trap;
  logic        mem_ack, mem_req, fill_valid, rd_done, wr_done, hold_odd_stages;
  logic        hold_even_stages, exec_bus_latch_ctl, opcode_latch_ctl, parity_error;
  logic [63:0] mem_data, shared_memory_bus;
  logic [15:0] cache_data_even, cache_data_odd;
  logic [3:0]  lat;
  logic        missed;
  int          bad_count, check_count, cyc, lat_a;

  tsc_cache #(.INDEX_W(4)) i_tsc_cache (.*);
  tsc_mem_model i_tsc_mem_model (.*);

  function automatic logic [15:0] hw(input logic [31:0] a);
    return {a[7:0], a[23:16]} ^ 16'h3C00;
  endfunction

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic fail_wait;
    bad_count++;
    $display("[FAIL] %0t wait ran out", $time);
    complete_run();
  endtask

  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cyc(input int got, input int exp);
    check_count++;
    if (got != exp) begin
      bad_count++;
      $display("[FAIL] %0t took %0d cycles expected %0d", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] exp, input logic experr);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fail_wait();
    chk_val({prdata, 31'h0, pslverr}, {wr ? prdata : exp, 31'h0, experr});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // kind 0 fetch, 1 operand read, 2 operand write
  task automatic access(input int kind, input logic [31:0] a, input logic wide,
                        input logic [31:0] d);
    @(posedge pclk);
    stage2_clock_edge          <= (kind == 0);
    stage7_clock_edge          <= (kind != 0);
    instruction_stream_counter <= a;
    operand_effective_address  <= a;
    op_write                   <= (kind == 2);
    op_wide                    <= wide;
    execution_data_bus         <= d;
    @(posedge pclk);
    stage2_clock_edge <= 1'b0;
    stage7_clock_edge <= 1'b0;
    cyc = 0;
    missed = 1'b0;
    do begin
      @(posedge pclk);
      cyc++;
      if (mem_req === 1'b1) begin
        missed = 1'b1;
        chk_val(kind == 0 ? hold_odd_stages : hold_even_stages, 1'b1);
        chk_val(memory_address_reg, {a[31:2], 2'b00});
      end
    end while ((kind == 2 ? wr_done : rd_done) !== 1'b1 && cyc < 60);
    if (cyc >= 60) fail_wait();
  endtask

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  initial begin
    {psel, penable, pwrite, stage2_clock_edge, stage7_clock_edge} = 5'h0;
    {op_write, op_wide, mem_trap} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    instruction_stream_counter = 32'h0;
    operand_effective_address = 32'h0;
    execution_data_bus = 32'h0;
    lat = 4'h2;
    bad_count = 0;
    check_count = 0;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0, 32'h1, 1'b0);
    apb(1'b1, 12'h000, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 12'h000, 32'h0, 32'h0, 1'b0);
    apb(1'b1, 12'h000, 32'h1, 32'h0, 1'b0);
    apb(1'b1, 12'h010, 32'hFFFF_FFFF, 32'h0, 1'b1);
    apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 12'h008, 32'h55, 32'h0, 1'b0);
    apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b0);
    $display("test registers done");
    access(0, A, 1'b1, 32'h0);
    chk_val(missed, 1'b1);
    apb(1'b0, 12'h00C, 32'h0, 32'h1, 1'b0);
    access(1, A, 1'b1, 32'h0);
    lat_a = cyc;
    chk_val(missed, 1'b0);
    chk_val({cache_data_even, cache_data_odd}, {hw(A), hw(A + 1)});
    chk_cyc(lat_a, 2);
    access(1, A + 1, 1'b1, 32'h0);
    chk_val({cache_data_odd, cache_data_even}, {hw(A + 1), hw(A + 2)});
    chk_cyc(cyc, lat_a + 2);
    access(1, A + 3, 1'b0, 32'h0);
    chk_val(cache_data_odd, hw(A + 3));
    $display("test reads done");
    access(2, A, 1'b1, 32'h1234_ABCD);
    lat_a = cyc;
    chk_cyc(lat_a, 4);
    access(1, A, 1'b1, 32'h0);
    chk_val({cache_data_even, cache_data_odd}, 32'h1234_ABCD);
    access(2, A + 1, 1'b1, 32'hCAFE_0BAD);
    chk_cyc(cyc, lat_a + 8);
    access(1, A + 1, 1'b1, 32'h0);
    chk_val({cache_data_odd, cache_data_even}, 32'hCAFE_0BAD);
    $display("test writes done");
    lat = 4'h9;
    access(1, B, 1'b1, 32'h0);
    chk_val({missed, cache_data_even, cache_data_odd}, {1'b1, hw(B), hw(B + 1)});
    access(1, A, 1'b1, 32'h0);
    chk_val({missed, cache_data_even}, {1'b0, 16'h1234});
    access(1, A + 32'h0002_0000, 1'b1, 32'h0);
    chk_val(missed, 1'b1);
    access(1, A, 1'b1, 32'h0);
    chk_val(missed, 1'b0);
    access(1, B, 1'b1, 32'h0);
    chk_val(missed, 1'b1);
    $display("test replacement done");
    lat = 4'hF;
    @(posedge pclk);
    operand_effective_address <= A + 32'h0004_0000;
    stage7_clock_edge         <= 1'b1;
    @(posedge pclk);
    stage7_clock_edge <= 1'b0;
    cyc = 0;
    while (mem_req !== 1'b1 && cyc < 20) begin
      @(posedge pclk);
      cyc++;
    end
    if (cyc >= 20) fail_wait();
    mem_trap <= 1'b1;
    @(posedge pclk);
    mem_trap <= 1'b0;
    @(posedge pclk);
    chk_val(mem_req, 1'b0);
    repeat (20) begin
      @(posedge pclk);
      chk_val(fill_valid, 1'b0);
    end
    // trap in the lookup cycle itself must stop the miss before it starts
    @(posedge pclk);
    stage7_clock_edge <= 1'b1;
    @(posedge pclk);
    stage7_clock_edge <= 1'b0;
    mem_trap          <= 1'b1;
    @(posedge pclk);
    mem_trap <= 1'b0;
    repeat (2) @(posedge pclk);
    chk_val({mem_req, hold_even_stages}, 2'b00);
    lat = 4'h0;
    access(1, A, 1'b1, 32'h0);
    chk_val(missed, 1'b0);
    apb(1'b0, 12'h00C, 32'h0, 32'h5, 1'b0);
    apb(1'b0, 12'h004, 32'h0, 32'h0, 1'b0);
    chk_val(parity_error, 1'b0);
    $display("test trap done");
    complete_run();
  end
endmodule
